// File: core/dcp_pkg.sv
// dcp_pkg: constants, types and register map of one digital I/O channel
// Behaviour
// R1: the channel runs in one mode: input, event counter, output or pulse output
// R2: the debounce period is 1 to 65535 ticks of 100 us, shared by input and counter
// R3: the filtered level changes only after the raw level held for the whole period
// R4: entering counter mode loads the counter with the starting value
// R5: count on rising, falling or both edges of the filtered input
// R6: with power-on run at stop the counter idles until a host start command
// R7: with power-on run at start the counter counts right after power-up
// R8: with scaling on the reported count is raw times slope plus offset
// R9: watchdog on and link lost puts the unit in safe state with safe outputs
// R10: watchdog off leaves outputs untouched when the link drops
// R11: the safe value selects the output during safe state, ON drives active
// R12: with auto clear on, safe state ends once the link is back
// R13: a plain output takes its power-on level, off by default
// R14: a plain output waits its power-on delay before taking that level
// R15: pulse mode makes a square wave with separate high and low tick widths
// R16: emit the set number of pulses, endless when the count is zero
// R17: after a finite burst the output stays low until restarted
// R18: a pulse channel powers up off, steadily on, or pulsing
// R19: a pulse channel waits its power-on delay before that behaviour
// R20: in safe state a pulse channel is held on or off by its safe value
package dcp_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_NS = 25;
	localparam int TICK_NS = 100000;
	localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_FILT = 8'h04;
	localparam logic [7:0] A_INIT = 8'h08;
	localparam logic [7:0] A_SLOPE = 8'h0c;
	localparam logic [7:0] A_OFFS = 8'h10;
	localparam logic [7:0] A_WIDTH = 8'h14;
	localparam logic [7:0] A_PCNT = 8'h18;
	localparam logic [7:0] A_DLY = 8'h1c;
	localparam logic [7:0] A_CMD = 8'h20;
	localparam logic [7:0] A_DOUT = 8'h24;
	localparam logic [7:0] A_STAT = 8'h28;
	localparam logic [7:0] A_COUNT = 8'h2c;
	localparam logic [7:0] A_RAW = 8'h30;
	// ----------------------------------------
	// command and status bits
	// ----------------------------------------
	localparam int C_CSTART = 0;
	localparam int C_CSTOP = 1;
	localparam int C_PSTART = 2;
	localparam int C_PSTOP = 3;
	localparam int C_SCLR = 4;
	localparam int CMD_W = 5;
	localparam int STAT_W = 6;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {DIO_IN = 2'h0, DIO_CNT = 2'h1, DIO_OUT = 2'h2, DIO_PLS = 2'h3} dcp_mode_t;
	typedef enum logic [1:0] {EDGE_RISE = 2'h0, EDGE_FALL = 2'h1, EDGE_BOTH = 2'h2} dcp_edge_t;
	typedef enum logic [1:0] {SEL_OFF = 2'h0, SEL_ON = 2'h1, SEL_PLS = 2'h2} dcp_sel_t;
	typedef enum logic [1:0] {PON_WAIT = 2'h1, PON_RUN = 2'h2} dcp_pon_t;
	typedef struct packed {
		logic [1:0] safe;
		logic [1:0] pon;
		logic auto_clr;
		logic wd_en;
		logic scale_en;
		logic run_at_pon;
		logic [1:0] edge_sel;
		logic [1:0] mode;
	} dcp_ctrl_t;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [11:0] RST_CTRL = 12'h000;
	localparam logic [15:0] RST_FILT = 16'h0001;
	localparam logic [15:0] RST_WIDTH = 16'h0001;
	localparam logic [31:0] RST_SLOPE = 32'h0000_0001;
	localparam logic [15:0] RST_DLY = 16'h0000;
endpackage : dcp_pkg

// File: core/dcp_filter.sv
// dcp_filter: debounce filter counted in 100 us ticks
module dcp_filter (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// sampling
	input wire logic tick_i,
	input wire logic raw_i,
	input wire logic [15:0] period_i,
	// result
	output logic level_o
);
	typedef struct packed {
		logic lvl;
		logic [15:0] cnt;
	} dcp_flt_t;
	dcp_flt_t q;
	dcp_flt_t d;
	logic [16:0] nxt;

	always_comb begin
		d = q;
		nxt = {1'b0, q.cnt} + 17'h00001;
		if (raw_i == q.lvl) begin
			d.cnt = 16'h0000; // R3
		end else if (tick_i) begin
			if (nxt >= {1'b0, period_i}) begin
				d.lvl = raw_i; // R2
				d.cnt = 16'h0000;
			end else begin
				d.cnt = nxt[15:0];
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level_o = q.lvl;

	property p_flt_hold;
		@(posedge sys_clk_i) disable iff (rst_i)
		(q.lvl != $past(q.lvl)) |-> $past(tick_i && raw_i != q.lvl && nxt >= {1'b0, period_i});
	endproperty
	a_flt_hold: assert property (p_flt_hold) else $error("filter changed before period elapsed"); // R3
endmodule : dcp_filter

// File: core/dcp_pulse.sv
// dcp_pulse: square wave generator with tick widths and pulse count
module dcp_pulse (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// control
	input wire logic tick_i,
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic [15:0] on_w_i,
	input wire logic [15:0] off_w_i,
	input wire logic [31:0] count_i,
	// output
	output logic out_o,
	output logic busy_o
);
	typedef struct packed {
		logic run;
		logic hi;
		logic inf;
		logic [15:0] w;
		logic [31:0] n;
	} dcp_pls_t;
	dcp_pls_t q;
	dcp_pls_t d;
	logic [16:0] nxt;
	logic [15:0] width;

	always_comb begin
		d = q;
		nxt = {1'b0, q.w} + 17'h00001;
		width = q.hi ? on_w_i : off_w_i;
		if (stop_i) begin
			d.run = 1'b0;
			d.hi = 1'b0;
		end else if (start_i) begin
			d.run = 1'b1;
			d.hi = 1'b1;
			d.w = 16'h0000;
			d.n = count_i;
			d.inf = (count_i == 32'h0000_0000); // R16
		end else if (q.run && tick_i) begin
			if (nxt >= {1'b0, width}) begin
				d.w = 16'h0000; // R15
				d.hi = ~q.hi;
				if (q.hi && !q.inf) begin
					d.n = q.n - 32'h0000_0001; // R16
					d.run = (q.n != 32'h0000_0001); // R17
				end
			end else begin
				d.w = nxt[15:0];
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign out_o = q.hi;
	assign busy_o = q.run;

	property p_pls_done;
		@(posedge sys_clk_i) disable iff (rst_i)
		(q.run && !d.run && !start_i) |=> !out_o;
	endproperty
	a_pls_done: assert property (p_pls_done) else $error("output not low after burst"); // R17
	property p_pls_inf;
		@(posedge sys_clk_i) disable iff (rst_i)
		(q.run && q.inf && !stop_i) |=> q.run;
	endproperty
	a_pls_inf: assert property (p_pls_inf) else $error("endless pulsing stopped"); // R16
endmodule : dcp_pulse

// File: core/dcp_channel.sv
// dcp_channel: one digital I/O channel with counter, output and pulse logic
//
// Strobed register access and the register addresses were decided locally.
module dcp_channel #(
	parameter dcp_pkg::dcp_ctrl_t CTRL_RST = dcp_pkg::RST_CTRL,
	parameter logic [15:0] DLY_RST = dcp_pkg::RST_DLY
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [31:0] rdata_o,
	// field and network
	input wire logic din_i,
	input wire logic link_i,
	output logic dout_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	localparam logic [11:0] TICK_MAX = 12'(dcp_pkg::TICK_CYC - 1);

	typedef struct packed {
		logic [1:0] din_s;
		logic [1:0] link_s;
		logic [11:0] tick_cnt;
		logic tick;
		dcp_pkg::dcp_ctrl_t ctrl;
		logic [15:0] filt;
		logic [31:0] init;
		logic [31:0] slope;
		logic [31:0] offs;
		logic [15:0] on_w;
		logic [15:0] off_w;
		logic [31:0] pcnt;
		logic [15:0] dly;
		logic do_lvl;
		logic [1:0] mode_p;
		logic filt_p;
		logic run;
		logic [31:0] cnt;
		logic safe;
		logic safe_p;
		logic hold;
		logic [15:0] pon_cnt;
		dcp_pkg::dcp_pon_t pst;
		logic dout;
		logic [31:0] rdata;
	} dcp_st_t;

	dcp_st_t q;
	dcp_st_t d;

	logic lvl;
	logic p_out;
	logic p_busy;
	logic p_start;
	logic p_stop;
	logic [dcp_pkg::CMD_W-1:0] cmd;
	logic is_cnt;
	logic is_out;
	logic is_pls;
	logic rise;
	logic fall;
	logic hit;
	logic load;
	logic fire;
	logic link;
	logic [63:0] prod;
	logic [31:0] scaled;
	logic [dcp_pkg::STAT_W-1:0] stat;
	logic out;

	// ----------------------------------------
	// sub blocks
	// ----------------------------------------
	dcp_filter u_filt (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.tick_i(q.tick),
		.raw_i(q.din_s[1]),
		.period_i(q.filt),
		.level_o(lvl)
	);

	dcp_pulse u_pls (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.tick_i(q.tick),
		.start_i(p_start),
		.stop_i(p_stop),
		.on_w_i(q.on_w),
		.off_w_i(q.off_w),
		.count_i(q.pcnt),
		.out_o(p_out),
		.busy_o(p_busy)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		d = q;
		// pin synchronisers
		d.din_s = {q.din_s[0], din_i};
		d.link_s = {q.link_s[0], link_i};
		link = q.link_s[1];
		// 100 us tick
		d.tick = (q.tick_cnt == TICK_MAX);
		if (d.tick) begin
			d.tick_cnt = 12'h000;
		end else begin
			d.tick_cnt = q.tick_cnt + 12'h001;
		end
		// mode decode
		is_cnt = (q.ctrl.mode == dcp_pkg::DIO_CNT); // R1
		is_out = (q.ctrl.mode == dcp_pkg::DIO_OUT);
		is_pls = (q.ctrl.mode == dcp_pkg::DIO_PLS);
		// commands
		cmd = '0;
		if (we_i && addr_i == dcp_pkg::A_CMD) begin
			cmd = wdata_i[dcp_pkg::CMD_W-1:0];
		end
		// register writes
		if (we_i) begin
			case (addr_i)
				dcp_pkg::A_CTRL: begin
					d.ctrl = wdata_i[11:0];
				end
				dcp_pkg::A_FILT: begin
					d.filt = wdata_i[15:0]; // R2
				end
				dcp_pkg::A_INIT: begin
					d.init = wdata_i;
				end
				dcp_pkg::A_SLOPE: begin
					d.slope = wdata_i;
				end
				dcp_pkg::A_OFFS: begin
					d.offs = wdata_i;
				end
				dcp_pkg::A_WIDTH: begin
					d.on_w = wdata_i[15:0];
					d.off_w = wdata_i[31:16];
				end
				dcp_pkg::A_PCNT: begin
					d.pcnt = wdata_i;
				end
				dcp_pkg::A_DLY: begin
					d.dly = wdata_i[15:0];
				end
				dcp_pkg::A_DOUT: begin
					d.do_lvl = wdata_i[0];
				end
				default: begin
				end
			endcase
		end
		// ----------------------------------------
		// event counter
		// ----------------------------------------
		d.mode_p = q.ctrl.mode;
		d.filt_p = lvl;
		rise = lvl & ~q.filt_p;
		fall = ~lvl & q.filt_p;
		case (q.ctrl.edge_sel)
			dcp_pkg::EDGE_RISE: hit = rise; // R5
			dcp_pkg::EDGE_FALL: hit = fall; // R5
			default: hit = rise | fall; // R5
		endcase
		if (cmd[dcp_pkg::C_CSTART]) begin
			d.run = 1'b1; // R6
		end else if (cmd[dcp_pkg::C_CSTOP]) begin
			d.run = 1'b0;
		end
		load = is_cnt && (q.mode_p != dcp_pkg::DIO_CNT);
		if (load) begin
			d.cnt = q.init; // R4
		end else if (is_cnt && q.run && hit) begin
			d.cnt = q.cnt + 32'h0000_0001; // R5
		end
		// ----------------------------------------
		// safe state
		// ----------------------------------------
		d.safe_p = q.safe;
		if (q.ctrl.wd_en && !link) begin
			d.safe = 1'b1; // R9
		end else if (cmd[dcp_pkg::C_SCLR]) begin
			d.safe = 1'b0;
		end else if (q.ctrl.auto_clr && link) begin
			d.safe = 1'b0; // R12
		end
		// ----------------------------------------
		// power-up sequence
		// ----------------------------------------
		fire = 1'b0;
		unique case (q.pst)
			dcp_pkg::PON_WAIT: begin
				if (q.pon_cnt >= q.dly) begin
					fire = 1'b1; // R14 R19
					d.pst = dcp_pkg::PON_RUN;
				end else if (q.tick) begin
					d.pon_cnt = q.pon_cnt + 16'h0001;
				end
			end
			dcp_pkg::PON_RUN: begin
			end
			default: begin
				d.pst = dcp_pkg::PON_WAIT;
			end
		endcase
		if (cmd[dcp_pkg::C_PSTART] || cmd[dcp_pkg::C_PSTOP]) begin
			d.hold = 1'b0;
		end
		if (fire) begin
			d.do_lvl = (q.ctrl.pon == dcp_pkg::SEL_ON); // R13
			d.hold = is_pls && (q.ctrl.pon == dcp_pkg::SEL_ON); // R18
		end
		// ----------------------------------------
		// pulse control
		// ----------------------------------------
		p_start = 1'b0;
		if (cmd[dcp_pkg::C_PSTART]) begin
			p_start = 1'b1;
		end
		if (fire && is_pls && q.ctrl.pon == dcp_pkg::SEL_PLS) begin
			p_start = 1'b1; // R18
		end
		if (q.safe && !q.safe_p && q.ctrl.safe == dcp_pkg::SEL_PLS) begin
			p_start = 1'b1; // R9
		end
		p_stop = cmd[dcp_pkg::C_PSTOP];
		if (!q.safe && q.safe_p && q.ctrl.safe == dcp_pkg::SEL_PLS) begin
			p_stop = 1'b1;
		end
		// ----------------------------------------
		// output selection
		// ----------------------------------------
		out = 1'b0;
		if (is_out || is_pls) begin
			if (q.safe) begin
				out = (q.ctrl.safe == dcp_pkg::SEL_ON); // R11 R20
				if (q.ctrl.safe == dcp_pkg::SEL_PLS) begin
					out = p_out; // R9
				end
			end else if (q.pst != dcp_pkg::PON_RUN) begin
				out = 1'b0; // R14 R19
			end else if (is_out) begin
				out = q.do_lvl; // R13 R10
			end else begin
				out = q.hold | p_out; // R15 R18
			end
		end
		d.dout = out;
		// ----------------------------------------
		// register reads
		// ----------------------------------------
		prod = q.cnt * q.slope;
		scaled = prod[31:0] + q.offs;
		stat = {p_busy, q.safe, q.run, lvl, q.dout, (q.pst == dcp_pkg::PON_RUN)};
		d.rdata = 32'h0000_0000;
		if (re_i) begin
			case (addr_i)
				dcp_pkg::A_CTRL: d.rdata = {20'h00000, q.ctrl};
				dcp_pkg::A_FILT: d.rdata = {16'h0000, q.filt};
				dcp_pkg::A_INIT: d.rdata = q.init;
				dcp_pkg::A_SLOPE: d.rdata = q.slope;
				dcp_pkg::A_OFFS: d.rdata = q.offs;
				dcp_pkg::A_WIDTH: d.rdata = {q.off_w, q.on_w};
				dcp_pkg::A_PCNT: d.rdata = q.pcnt;
				dcp_pkg::A_DLY: d.rdata = {16'h0000, q.dly};
				dcp_pkg::A_DOUT: d.rdata = {31'h0000_0000, q.do_lvl};
				dcp_pkg::A_STAT: d.rdata = {26'h000_0000, stat};
				dcp_pkg::A_COUNT: d.rdata = q.ctrl.scale_en ? scaled : q.cnt; // R8
				dcp_pkg::A_RAW: d.rdata = q.cnt;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.link_s <= 2'h3; // link seen as present so reset does not trip the watchdog
			q.ctrl <= CTRL_RST;
			q.run <= CTRL_RST.run_at_pon; // R6 R7
			q.filt <= dcp_pkg::RST_FILT;
			q.on_w <= dcp_pkg::RST_WIDTH;
			q.off_w <= dcp_pkg::RST_WIDTH;
			q.slope <= dcp_pkg::RST_SLOPE;
			q.dly <= DLY_RST;
			q.pst <= dcp_pkg::PON_WAIT;
		end else begin
			q <= d;
		end
	end

	assign rdata_o = q.rdata;
	assign dout_o = q.dout;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	property p_in_quiet;
		(q.ctrl.mode == dcp_pkg::DIO_IN || q.ctrl.mode == dcp_pkg::DIO_CNT) |=> !dout_o;
	endproperty
	a_in_quiet: assert property (p_in_quiet) else $error("output driven in input mode"); // R1
	property p_load;
		(is_cnt && q.mode_p != dcp_pkg::DIO_CNT) |=> (q.cnt == $past(q.init));
	endproperty
	a_load: assert property (p_load) else $error("counter not loaded on mode entry"); // R4
	property p_count;
		(is_cnt && !load && q.run && hit) |=> (q.cnt == $past(q.cnt) + 32'h0000_0001);
	endproperty
	a_count: assert property (p_count) else $error("edge not counted"); // R5
	property p_idle;
		(!q.run && !load && !cmd[dcp_pkg::C_CSTART]) |=> $stable(q.cnt);
	endproperty
	a_idle: assert property (p_idle) else $error("stopped counter moved"); // R6
	property p_scale;
		(re_i && addr_i == dcp_pkg::A_COUNT && q.ctrl.scale_en && !we_i) |=>
			(rdata_o == $past(q.cnt) * $past(q.slope) + $past(q.offs));
	endproperty
	a_scale: assert property (p_scale) else $error("scaled value wrong"); // R8
	property p_safe_in;
		(q.ctrl.wd_en && !link) |=> q.safe;
	endproperty
	a_safe_in: assert property (p_safe_in) else $error("safe state not entered"); // R9
	property p_no_wd;
		(!q.ctrl.wd_en && !q.safe) |=> !q.safe;
	endproperty
	a_no_wd: assert property (p_no_wd) else $error("safe state without watchdog"); // R10
	property p_safe_on;
		(q.safe && (is_out || is_pls) && q.ctrl.safe == dcp_pkg::SEL_ON) |=> dout_o;
	endproperty
	a_safe_on: assert property (p_safe_on) else $error("safe on not driven"); // R11
	property p_auto;
		(q.safe && q.ctrl.auto_clr && link) |=> !q.safe;
	endproperty
	a_auto: assert property (p_auto) else $error("safe state not cleared"); // R12
	property p_delay;
		(q.pst == dcp_pkg::PON_WAIT && !q.safe && !fire) |=> !dout_o;
	endproperty
	a_delay: assert property (p_delay) else $error("output before power-on delay"); // R14
	property p_safe_off;
		(q.safe && is_pls && q.ctrl.safe == dcp_pkg::SEL_OFF) |=> !dout_o;
	endproperty
	a_safe_off: assert property (p_safe_off) else $error("pulse channel not held off"); // R20

	c_count: cover property (is_cnt && q.run && hit);
	c_safe: cover property (q.safe ##1 !q.safe);
	c_pulse: cover property (is_pls && $rose(dout_o));
endmodule : dcp_channel

// File: test/dcp_field_model.sv
// dcp_field_model: field switch on the input, actuator watching the output
module dcp_field_model (
	// clock
	input wire logic sys_clk_i,
	// actuator side
	input wire logic dout_i,
	// switch side
	output logic din_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int rises;
	int high_run;
	int last_high;
	logic prev;
	initial begin
		din_o = 1'b0;
		rises = 0;
		high_run = 0;
		last_high = 0;
		prev = 1'b0;
	end
	// ----------------------------------------
	// actuator: count pulses, measure the last high phase
	// ----------------------------------------
	always @(posedge sys_clk_i) begin
		prev <= dout_i;
		if (dout_i && !prev) begin
			rises <= rises + 1;
		end
		if (dout_i) begin
			high_run <= high_run + 1;
		end else begin
			if (prev) begin
				last_high <= high_run;
			end
			high_run <= 0;
		end
	end
	// ----------------------------------------
	// switch: steady level or a short bounce
	// ----------------------------------------
	task automatic hold(input logic level, input int n);
		@(posedge sys_clk_i);
		din_o <= level;
		repeat (n) @(posedge sys_clk_i);
	endtask : hold
	task automatic bounce(input logic level, input int n);
		hold(level, n);
		din_o <= !level;
	endtask : bounce
	task automatic clear();
		@(posedge sys_clk_i);
		rises <= 0;
	endtask : clear
endmodule : dcp_field_model

// File: test/tb_dio_channel_counter_pulse.sv
// tb_dio_channel_counter_pulse: self-checking bench of one digital I/O channel
`define CHK(got, exp) begin \
	checks_done++; \
	if ((got) !== (exp)) begin \
		errors++; \
		$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
	end \
end
module tb_dio_channel_counter_pulse;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int T = dcp_pkg::TICK_CYC;
	typedef struct packed {
		logic w;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} dcp_row_t;
	logic sys_clk;
	logic rst;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic we;
	logic re;
	logic re2;
	logic [31:0] rdata;
	logic [31:0] rdata2;
	logic din;
	logic link1;
	logic link2;
	logic dout1;
	logic dout2;
	logic dout3;
	logic [31:0] rv;
	int errors;
	int checks_done;
	dcp_row_t rows [19] = '{
		'{1'b0, dcp_pkg::A_CTRL, 32'h0, 32'h0}, '{1'b0, dcp_pkg::A_FILT, 32'h0, 32'h1},
		'{1'b0, dcp_pkg::A_INIT, 32'h0, 32'h0}, '{1'b0, dcp_pkg::A_SLOPE, 32'h0, 32'h1},
		'{1'b0, dcp_pkg::A_OFFS, 32'h0, 32'h0}, '{1'b0, dcp_pkg::A_WIDTH, 32'h0, 32'h0001_0001},
		'{1'b0, dcp_pkg::A_PCNT, 32'h0, 32'h0}, '{1'b0, dcp_pkg::A_DLY, 32'h0, 32'h0},
		'{1'b0, dcp_pkg::A_DOUT, 32'h0, 32'h0}, '{1'b0, 8'h34, 32'h0, 32'h0},
		'{1'b1, dcp_pkg::A_FILT, 32'hffff_0001, 32'h1}, '{1'b1, dcp_pkg::A_INIT, 32'h5, 32'h5},
		'{1'b1, dcp_pkg::A_SLOPE, 32'h3, 32'h3}, '{1'b1, dcp_pkg::A_OFFS, 32'h2, 32'h2},
		'{1'b1, dcp_pkg::A_WIDTH, 32'h0001_0001, 32'h0001_0001}, '{1'b1, dcp_pkg::A_PCNT, 32'h2, 32'h2},
		'{1'b1, dcp_pkg::A_DLY, 32'h1234_beef, 32'h0000_beef}, '{1'b1, dcp_pkg::A_DOUT, 32'h1, 32'h1},
		'{1'b1, 8'h34, 32'hffff_ffff, 32'h0}};
	// ----------------------------------------
	// design, two power-on variants and field side
	// ----------------------------------------
	dcp_channel dut (.sys_clk_i(sys_clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
		.rdata_o(rdata), .din_i(din), .link_i(link1), .dout_o(dout1));
	dcp_channel #(.CTRL_RST(dcp_pkg::dcp_ctrl_t'(12'h1d2)), .DLY_RST(16'h0002)) dut_pwr (.sys_clk_i(sys_clk),
		.rst_i(rst), .addr_i(addr), .wdata_i(wdata), .we_i(1'b0), .re_i(re2), .rdata_o(rdata2), .din_i(din),
		.link_i(link2), .dout_o(dout2));
	dcp_channel #(.CTRL_RST(dcp_pkg::dcp_ctrl_t'(12'h103)), .DLY_RST(16'h0001)) dut_pls (.sys_clk_i(sys_clk),
		.rst_i(rst), .addr_i(addr), .wdata_i(wdata), .we_i(1'b0), .re_i(1'b0), .rdata_o(), .din_i(din),
		.link_i(1'b1), .dout_o(dout3));
	dcp_field_model field (.sys_clk_i(sys_clk), .dout_i(dout1), .din_o(din));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// ----------------------------------------
	// bus cycles and helpers
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge sys_clk);
		we <= 1'b0;
	endtask : wr
	task automatic rd(input logic sel, input logic [7:0] a);
		@(posedge sys_clk);
		addr <= a;
		re <= !sel;
		re2 <= sel;
		@(posedge sys_clk);
		re <= 1'b0;
		re2 <= 1'b0;
		#1 rv = sel ? rdata2 : rdata;
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic flip(input logic level);
		field.hold(level, T + 10);
	endtask : flip
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (95000) @(posedge sys_clk);
		errors++;
		give_verdict();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		addr = 8'h00;
		wdata = 32'h0;
		we = 1'b0;
		re = 1'b0;
		re2 = 1'b0;
		link1 = 1'b1;
		link2 = 1'b1;
		errors = 0;
		checks_done = 0;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		cyc(2);
		`CHK(dout2, 1'b0);
		`CHK(dout3, 1'b0);
		rd(1'b1, dcp_pkg::A_STAT);
		`CHK(rv[3], 1'b1);
		`CHK(rv[0], 1'b0);
		rd(1'b0, dcp_pkg::A_STAT);
		`CHK(rv[3], 1'b0);
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d);
			end
			rd(1'b0, rows[i].a);
			`CHK(rv, rows[i].e);
		end
		// event counter: load, edge selection, start command, scaling
		wr(dcp_pkg::A_CTRL, 32'h001);
		rd(1'b0, dcp_pkg::A_RAW);
		`CHK(rv, 32'h5);
		flip(1'b1);
		rd(1'b0, dcp_pkg::A_RAW);
		`CHK(rv, 32'h5);
		wr(dcp_pkg::A_CMD, 32'h1);
		flip(1'b0);
		flip(1'b1);
		rd(1'b0, dcp_pkg::A_RAW);
		`CHK(rv, 32'h6);
		wr(dcp_pkg::A_CTRL, 32'h005);
		flip(1'b0);
		rd(1'b0, dcp_pkg::A_RAW);
		`CHK(rv, 32'h7);
		wr(dcp_pkg::A_CTRL, 32'h009);
		flip(1'b1);
		flip(1'b0);
		rd(1'b0, dcp_pkg::A_RAW);
		`CHK(rv, 32'h9);
		wr(dcp_pkg::A_CTRL, 32'h029);
		rd(1'b0, dcp_pkg::A_COUNT);
		`CHK(rv, 32'h1d);
		wr(dcp_pkg::A_CTRL, 32'h000);
		wr(dcp_pkg::A_CTRL, 32'h001);
		rd(1'b0, dcp_pkg::A_RAW);
		`CHK(rv, 32'h5);
		// power-on level after the delay, then watchdog with auto clear
		`CHK(dout2, 1'b1);
		`CHK(dout3, 1'b1);
		link2 <= 1'b0;
		cyc(8);
		`CHK(dout2, 1'b0);
		link2 <= 1'b1;
		cyc(8);
		`CHK(dout2, 1'b1);
		// debounce: a short bounce is dropped, a long hold passes
		wr(dcp_pkg::A_FILT, 32'h2);
		field.bounce(1'b1, T / 2);
		cyc(2 * T + 10);
		rd(1'b0, dcp_pkg::A_STAT);
		`CHK(rv[2], 1'b0);
		field.hold(1'b1, T - 50);
		rd(1'b0, dcp_pkg::A_STAT);
		`CHK(rv[2], 1'b0);
		cyc(T + 70);
		rd(1'b0, dcp_pkg::A_STAT);
		`CHK(rv[2], 1'b1);
		// finite and endless pulse bursts
		wr(dcp_pkg::A_CTRL, 32'h003);
		field.clear();
		wr(dcp_pkg::A_CMD, 32'h4);
		cyc(5 * T + 20);
		`CHK(field.rises, 2);
		`CHK((field.last_high >= T - 1) && (field.last_high <= T + 1), 1'b1);
		`CHK(dout1, 1'b0);
		rd(1'b0, dcp_pkg::A_STAT);
		`CHK(rv[5], 1'b0);
		wr(dcp_pkg::A_PCNT, 32'h0);
		field.clear();
		wr(dcp_pkg::A_CMD, 32'h4);
		cyc(4 * T + 20);
		`CHK(field.rises >= 3, 1'b1);
		rd(1'b0, dcp_pkg::A_STAT);
		`CHK(rv[5], 1'b1);
		wr(dcp_pkg::A_CMD, 32'h8);
		// safe state on a pulse channel, cleared by command only
		wr(dcp_pkg::A_CTRL, 32'h443);
		link1 <= 1'b0;
		cyc(8);
		`CHK(dout1, 1'b1);
		rd(1'b0, dcp_pkg::A_STAT);
		`CHK(rv[4], 1'b1);
		wr(dcp_pkg::A_CMD, 32'h10);
		cyc(2);
		`CHK(dout1, 1'b1);
		link1 <= 1'b1;
		cyc(8);
		`CHK(dout1, 1'b1);
		wr(dcp_pkg::A_CMD, 32'h10);
		cyc(3);
		`CHK(dout1, 1'b0);
		// plain output ignores the link with the watchdog off
		wr(dcp_pkg::A_CTRL, 32'h002);
		cyc(2);
		`CHK(dout1, 1'b1);
		link1 <= 1'b0;
		cyc(8);
		`CHK(dout1, 1'b1);
		link1 <= 1'b1;
		wr(dcp_pkg::A_CTRL, 32'h000);
		cyc(2);
		`CHK(dout1, 1'b0);
		give_verdict();
	end
endmodule : tb_dio_channel_counter_pulse
